// ### design/pth_pkg.sv
// package for the 8-bit period timer: register map, fields, reset values, carriers
// assumes an apb master with 32-bit data and byte addresses in the low 8 bits
package pth_pkg;

    localparam int unsigned DATA_W      = 32;
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned CNT_W       = 8;
    localparam int unsigned PSC_SEL_W   = 3;
    localparam int unsigned PSC_CNT_W   = 7;
    localparam int unsigned POST_W      = 4;
    localparam int unsigned POST_SEL_W  = 5;
    localparam int unsigned MODE_W      = 5;
    localparam int unsigned N_EXT_SRC   = 4;
    localparam int unsigned SRC_SEL_W   = 2;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_TIMER_COUNT    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PERIOD_SETTING = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TIMER_CONTROL  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_TIMER_CTRL_ONE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_HW_LIMIT_CTRL  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_EXT_RST_SEL    = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS         = 8'h18;

    // field positions
    localparam int unsigned CTRL_RUN_BIT   = 0;
    localparam int unsigned CTRL_PSC_LSB   = 4;
    localparam int unsigned STAT_RUN_BIT   = 0;
    localparam int unsigned STAT_START_BIT = 1;
    localparam int unsigned STAT_ERS_BIT   = 2;
    localparam int unsigned STAT_POST_LSB  = 8;

    // values after reset
    localparam logic [CNT_W-1:0]      RST_TIMER_COUNT = 8'h00;
    localparam logic [CNT_W-1:0]      RST_PERIOD      = 8'hff;
    localparam logic [PSC_SEL_W-1:0]  RST_PSC_SEL     = 3'h0;
    localparam logic [POST_SEL_W-1:0] RST_POST_SEL    = 5'h00;
    localparam logic [MODE_W-1:0]     RST_MODE        = 5'h00;
    localparam logic [SRC_SEL_W-1:0]  RST_SRC_SEL     = 2'h0;

    // mode field: upper two bits pick the group
    localparam logic [1:0] GRP_FREE     = 2'h0;
    localparam logic [1:0] GRP_ONESHOT  = 2'h1;
    localparam logic [1:0] GRP_MONO     = 2'h2;

    // edge kinds: none, rising, falling, either
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_ANY  = 2'h3;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } pth_apb_req_t;

endpackage : pth_pkg

// ### design/pth_prescaler.sv
// programmable power-of-two prescaler, ratios 1:1 up to 1:2**(2**SEL_W-1)
// assumes clear and enable come from the timer core in the same clock domain
module pth_prescaler #(
    parameter int unsigned SEL_W = 3,
    parameter int unsigned CNT_W = 7
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic             clear_i,
    input  wire logic             en_i,
    input  wire logic [SEL_W-1:0] ratio_sel_i,
    output logic                  tick_o
);

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] limit;

    assign limit  = CNT_W'((32'd1 << ratio_sel_i) - 32'd1);
    assign tick_o = en_i && (cnt_ff == limit);

    // held while disabled so a gated timer resumes mid-division
    always_ff @(posedge clk_i) begin
        if (srst_i || clear_i) begin
            cnt_ff <= '0;
        end else if (en_i) begin
            cnt_ff <= tick_o ? '0 : cnt_ff + 1'b1;
        end
    end

endmodule : pth_prescaler

// ### design/pth_timer.sv
// 8-bit period timer with prescaler, postscaler, double-buffered period
// and hardware-limit modes driven by a selectable external reset source.
// assumes ext sources are synchronous to clk_i; registers over apb.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
module pth_timer (
    input  wire logic                               clk_i,
    input  wire logic                               srst_i,
    input  wire pth_pkg::pth_apb_req_t              apb_req_i,
    output logic                                    apb_pready_o,
    output logic [pth_pkg::DATA_W-1:0]              apb_prdata_o,
    output logic                                    apb_pslverr_o,
    input  wire logic [pth_pkg::N_EXT_SRC-1:0]      ext_reset_src_i,
    input  wire logic                               debug_freeze_i,
    output logic [pth_pkg::CNT_W-1:0]               timer_count_o,
    output logic                                    period_match_o,
    output logic                                    postscaled_pulse_o
);

    // register state
    logic [pth_pkg::CNT_W-1:0]      timer_count_ff;
    logic [pth_pkg::CNT_W-1:0]      period_setting_ff;
    logic [pth_pkg::CNT_W-1:0]      period_buffer_ff;
    logic                           run_enable_ff;
    logic [pth_pkg::PSC_SEL_W-1:0]  psc_sel_ff;
    logic [pth_pkg::POST_SEL_W-1:0] postscale_select_ff;
    logic [pth_pkg::MODE_W-1:0]     mode_ff;
    logic [pth_pkg::SRC_SEL_W-1:0]  ext_reset_select_ff;
    logic [pth_pkg::POST_W-1:0]     post_cnt_ff;
    logic                           started_ff;
    logic                           ers_prev_ff;
    logic                           pulse_ff;
    logic                           match_ff;
    logic                           pready_ff;
    logic                           pslverr_ff;
    logic [pth_pkg::DATA_W-1:0]     prdata_ff;

    // decoded control
    logic [1:0] grp;
    logic [2:0] sub;
    logic       is_free;
    logic       is_os;
    logic       is_mono;
    logic       is_lvl_os;
    logic       mode_valid;
    logic [1:0] start_kind;
    logic [1:0] rst_kind;
    logic       lvl_rst_mode;
    logic       gate_ok;

    logic ers_raw;
    logic ers_eff;
    logic ers_rise;
    logic ers_fall;
    logic start_evt;
    logic edge_rst;
    logic level_rst;
    logic ext_rst_evt;
    logic run_ok;
    logic tick;
    logic match;
    logic match_tick;
    logic post_hit;
    logic stop_clears_run;

    logic                       acc;
    logic                       wr_en;
    logic                       wr_count;
    logic                       wr_ctrl;
    logic                       psc_clear;
    logic [pth_pkg::DATA_W-1:0] rd_word;
    logic                       rd_hit;

    // true when the selected edge kind has occurred this cycle
    function automatic logic edge_hit(input logic [1:0] kind,
                                      input logic       rise,
                                      input logic       fall);
        logic r;
        r = 1'b0;
        case (kind)
            pth_pkg::EDGE_RISE: r = rise;
            pth_pkg::EDGE_FALL: r = fall;
            pth_pkg::EDGE_ANY:  r = rise | fall;
            default:            r = 1'b0;
        endcase
        return r;
    endfunction : edge_hit

    // ---------------- mode decode ----------------
    assign grp       = mode_ff[4:3];
    assign sub       = mode_ff[2:0];
    assign is_free   = (grp == pth_pkg::GRP_FREE);
    assign is_os     = (grp == pth_pkg::GRP_ONESHOT);
    assign is_mono   = (grp == pth_pkg::GRP_MONO) && (sub != 3'h0) && (sub[2] == 1'b0);
    assign is_lvl_os = (grp == pth_pkg::GRP_MONO) && (sub[2:1] == 2'b11);
    // reserved codes never count
    assign mode_valid = is_free | is_os | is_mono | is_lvl_os;

    always_comb begin
        start_kind = pth_pkg::EDGE_NONE;
        rst_kind   = pth_pkg::EDGE_NONE;
        if (is_os) begin
            if (sub[2] == 1'b0) begin
                start_kind = sub[1:0];
            end else begin
                start_kind = sub[0] ? pth_pkg::EDGE_FALL : pth_pkg::EDGE_RISE;
            end
            if (sub[2:1] == 2'b10) begin
                rst_kind = sub[0] ? pth_pkg::EDGE_FALL : pth_pkg::EDGE_RISE;
            end
        end else if (is_mono) begin
            start_kind = sub[1:0];
        end else if (is_free) begin
            case (sub)
                3'h3:    rst_kind = pth_pkg::EDGE_ANY;
                3'h4:    rst_kind = pth_pkg::EDGE_RISE;
                3'h5:    rst_kind = pth_pkg::EDGE_FALL;
                default: rst_kind = pth_pkg::EDGE_NONE;
            endcase
        end
    end

    assign lvl_rst_mode = (sub[2:1] == 2'b11) && (is_free | is_os | is_lvl_os);

    // ---------------- external source ----------------
    assign ers_raw = ext_reset_src_i[ext_reset_select_ff];
    // frozen source looks constant, so neither edges nor level changes land
    assign ers_eff  = debug_freeze_i ? ers_prev_ff : ers_raw;
    assign ers_rise = ers_eff & ~ers_prev_ff;
    assign ers_fall = ~ers_eff & ers_prev_ff;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ers_prev_ff <= 1'b0;
        end else begin
            ers_prev_ff <= ers_eff;
        end
    end

    always_comb begin
        gate_ok = 1'b1;
        if (is_free && sub == 3'h1) begin
            gate_ok = ers_eff;
        end else if (is_free && sub == 3'h2) begin
            gate_ok = ~ers_eff;
        end
    end

    assign start_evt   = run_enable_ff && edge_hit(start_kind, ers_rise, ers_fall);
    assign edge_rst    = run_enable_ff && edge_hit(rst_kind, ers_rise, ers_fall);
    assign level_rst   = run_enable_ff && lvl_rst_mode && (sub[0] ? ers_eff : ~ers_eff);
    assign ext_rst_evt = edge_rst | level_rst;

    assign run_ok = run_enable_ff && mode_valid && gate_ok && !level_rst
                  && ((start_kind == pth_pkg::EDGE_NONE) || started_ff);

    // ---------------- counting ----------------
    assign acc       = apb_req_i.psel && apb_req_i.penable && pready_ff;
    assign wr_en     = acc && apb_req_i.pwrite;
    assign wr_count  = wr_en && (apb_req_i.paddr == pth_pkg::OFS_TIMER_COUNT);
    assign wr_ctrl   = wr_en && (apb_req_i.paddr == pth_pkg::OFS_TIMER_CONTROL);
    assign psc_clear = wr_count | wr_ctrl | ext_rst_evt;

    pth_prescaler #(
        .SEL_W (pth_pkg::PSC_SEL_W),
        .CNT_W (pth_pkg::PSC_CNT_W)
    ) u_prescaler (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .clear_i     (psc_clear),
        .en_i        (run_ok),
        .ratio_sel_i (psc_sel_ff),
        .tick_o      (tick)
    );

    assign match           = (timer_count_ff == period_buffer_ff);
    assign match_tick      = tick && match && !psc_clear;
    assign post_hit        = (post_cnt_ff == postscale_select_ff[pth_pkg::POST_W-1:0]);
    assign stop_clears_run = is_os | is_lvl_os;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            timer_count_ff <= pth_pkg::RST_TIMER_COUNT;
        end else if (wr_count) begin
            timer_count_ff <= apb_req_i.pwdata[pth_pkg::CNT_W-1:0];
        end else if (ext_rst_evt) begin
            timer_count_ff <= '0;
        end else if (match_tick) begin
            timer_count_ff <= '0;
        end else if (tick && !wr_ctrl) begin
            timer_count_ff <= timer_count_ff + 1'b1;
        end
    end

    // control write never touches the count above
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            period_buffer_ff <= pth_pkg::RST_PERIOD;
        end else if (wr_count || wr_ctrl || ext_rst_evt || match_tick) begin
            period_buffer_ff <= period_setting_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || psc_clear) begin
            post_cnt_ff <= '0;
        end else if (match_tick) begin
            post_cnt_ff <= post_hit ? '0 : post_cnt_ff + 1'b1;
        end
    end

    // pulse stands until the next tick, but drops sooner on a prescaler clear or once run enable clears
    always_ff @(posedge clk_i) begin
        if (srst_i || psc_clear || !run_enable_ff) begin
            pulse_ff <= 1'b0;
        end else if (tick) begin
            pulse_ff <= match_tick && post_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            match_ff <= 1'b0;
        end else begin
            match_ff <= match_tick;
        end
    end

    // software set wins over a hardware stop in the same cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            run_enable_ff <= 1'b0;
        end else if (wr_ctrl) begin
            run_enable_ff <= apb_req_i.pwdata[pth_pkg::CTRL_RUN_BIT];
        end else if (match_tick && stop_clears_run) begin
            run_enable_ff <= 1'b0;
        end
    end

    // edge arm; a start edge beats a monostable stop in the same cycle
    always_ff @(posedge clk_i) begin
        if (srst_i || !run_enable_ff) begin
            started_ff <= 1'b0;
        end else if (start_evt) begin
            started_ff <= 1'b1;
        end else if (match_tick && is_mono) begin
            started_ff <= 1'b0;
        end
    end

    // ---------------- configuration registers ----------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            period_setting_ff <= pth_pkg::RST_PERIOD;
        end else if (wr_en && apb_req_i.paddr == pth_pkg::OFS_PERIOD_SETTING) begin
            period_setting_ff <= apb_req_i.pwdata[pth_pkg::CNT_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            psc_sel_ff <= pth_pkg::RST_PSC_SEL;
        end else if (wr_ctrl) begin
            psc_sel_ff <= apb_req_i.pwdata[pth_pkg::CTRL_PSC_LSB +: pth_pkg::PSC_SEL_W];
        end
    end

    // only the low four bits steer the postscaler: 1:16 at most
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            postscale_select_ff <= pth_pkg::RST_POST_SEL;
        end else if (wr_en && apb_req_i.paddr == pth_pkg::OFS_TIMER_CTRL_ONE) begin
            postscale_select_ff <= apb_req_i.pwdata[pth_pkg::POST_SEL_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mode_ff <= pth_pkg::RST_MODE;
        end else if (wr_en && apb_req_i.paddr == pth_pkg::OFS_HW_LIMIT_CTRL) begin
            mode_ff <= apb_req_i.pwdata[pth_pkg::MODE_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ext_reset_select_ff <= pth_pkg::RST_SRC_SEL;
        end else if (wr_en && apb_req_i.paddr == pth_pkg::OFS_EXT_RST_SEL) begin
            ext_reset_select_ff <= apb_req_i.pwdata[pth_pkg::SRC_SEL_W-1:0];
        end
    end

    // ---------------- apb read side ----------------
    // period buffer deliberately has no read path
    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        case (apb_req_i.paddr)
            pth_pkg::OFS_TIMER_COUNT: begin
                rd_word[pth_pkg::CNT_W-1:0] = timer_count_ff;
            end
            pth_pkg::OFS_PERIOD_SETTING: begin
                rd_word[pth_pkg::CNT_W-1:0] = period_setting_ff;
            end
            pth_pkg::OFS_TIMER_CONTROL: begin
                rd_word[pth_pkg::CTRL_RUN_BIT] = run_enable_ff;
                rd_word[pth_pkg::CTRL_PSC_LSB +: pth_pkg::PSC_SEL_W] = psc_sel_ff;
            end
            pth_pkg::OFS_TIMER_CTRL_ONE: begin
                rd_word[pth_pkg::POST_SEL_W-1:0] = postscale_select_ff;
            end
            pth_pkg::OFS_HW_LIMIT_CTRL: begin
                rd_word[pth_pkg::MODE_W-1:0] = mode_ff;
            end
            pth_pkg::OFS_EXT_RST_SEL: begin
                rd_word[pth_pkg::SRC_SEL_W-1:0] = ext_reset_select_ff;
            end
            pth_pkg::OFS_STATUS: begin
                rd_word[pth_pkg::STAT_RUN_BIT]   = run_ok;
                rd_word[pth_pkg::STAT_START_BIT] = started_ff;
                rd_word[pth_pkg::STAT_ERS_BIT]   = ers_prev_ff;
                rd_word[pth_pkg::STAT_POST_LSB +: pth_pkg::POST_W] = post_cnt_ff;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // one wait state: answer on the second access cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else begin
            pready_ff  <= apb_req_i.psel && apb_req_i.penable && !pready_ff;
            pslverr_ff <= apb_req_i.psel && apb_req_i.penable && !pready_ff && !rd_hit;
            if (apb_req_i.psel && apb_req_i.penable && !pready_ff && !apb_req_i.pwrite) begin
                prdata_ff <= rd_word;
            end
        end
    end

    assign apb_pready_o       = pready_ff;
    assign apb_prdata_o       = prdata_ff;
    assign apb_pslverr_o      = pslverr_ff;
    assign timer_count_o      = timer_count_ff;
    assign period_match_o     = match_ff;
    assign postscaled_pulse_o = pulse_ff;

endmodule : pth_timer

// ### verif/pth_timer_sva.sv
// assertion checker for the period timer, bound to its top module
// assumes one clock domain and an apb master that holds requests until pready
module pth_timer_sva (
    input wire logic                      clk_i,
    input wire logic                      srst_i,
    input wire pth_pkg::pth_apb_req_t     apb_req_i,
    input wire logic                      apb_pready_o,
    input wire logic                      apb_pslverr_o,
    input wire logic [pth_pkg::CNT_W-1:0] timer_count_o,
    input wire logic                      period_match_o,
    input wire logic                      postscaled_pulse_o
);
    logic run_ff;

    // software view of run enable only; a one-shot hardware clear is not tracked
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            run_ff <= 1'b0;
        end else if (apb_pready_o && apb_req_i.pwrite
                     && apb_req_i.paddr == pth_pkg::OFS_TIMER_CONTROL) begin
            run_ff <= apb_req_i.pwdata[0];
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    ready_time_a: assert property (
        apb_req_i.psel && apb_req_i.penable && !apb_pready_o |=> apb_pready_o)
        else $error("pready late");
    ready_pulse_a: assert property (
        apb_pready_o |-> apb_req_i.psel && apb_req_i.penable ##1 !apb_pready_o)
        else $error("pready not a single cycle in access");
    unmapped_err_a: assert property (
        apb_pready_o |-> apb_pslverr_o == (apb_req_i.paddr > pth_pkg::OFS_STATUS
                                           || apb_req_i.paddr[1:0] != 2'h0))
        else $error("pslverr wrong for address");
    err_ready_a: assert property (
        apb_pslverr_o |-> apb_pready_o)
        else $error("pslverr without pready");
    reset_clear_a: assert property (
        $fell(srst_i) |-> timer_count_o == 8'h00 && !postscaled_pulse_o)
        else $error("count not cleared by reset");
    pulse_zero_a: assert property (
        $rose(postscaled_pulse_o) |-> timer_count_o == 8'h00)
        else $error("pulse off the match tick");
    match_zero_a: assert property (
        $rose(period_match_o) |-> timer_count_o == 8'h00)
        else $error("match flag without count return");
    hold_stopped_a: assert property (
        !run_ff && !apb_pready_o |=> $stable(timer_count_o))
        else $error("count moved while stopped");
    no_pulse_a: assert property (
        !run_ff && !apb_pready_o |=> !$rose(postscaled_pulse_o))
        else $error("pulse while stopped");
endmodule : pth_timer_sva

bind pth_timer pth_timer_sva chk_u (
    .clk_i              (clk_i),
    .srst_i             (srst_i),
    .apb_req_i          (apb_req_i),
    .apb_pready_o       (apb_pready_o),
    .apb_pslverr_o      (apb_pslverr_o),
    .timer_count_o      (timer_count_o),
    .period_match_o     (period_match_o),
    .postscaled_pulse_o (postscaled_pulse_o)
);

// ### verif/pth_ers_model.sv
// model of the logic driving the external reset sources
// assumes prescale 1:1, so one timer tick is one clk_i cycle
module pth_ers_model (
    input wire logic  clk_i,
    output logic [3:0] src_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial src_o = 4'h0;

    // waits six ticks before any change: keeps edge spacing and level length
    task automatic set_level(input int idx, input logic v);
        repeat (6) @(posedge clk_i);
        src_o[idx] <= v;
    endtask : set_level
endmodule : pth_ers_model

// ### verif/tb.sv
// self-checking bench for the period timer: apb tasks, one task per scenario
// assumes prescale 1:1 wherever ticks are counted
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  clk_i = 1'b0;
    logic                  srst_i = 1'b1;
    pth_pkg::pth_apb_req_t req = '0;
    logic                  freeze = 1'b0;
    logic                  pready, perr, pmatch, pulse, err;
    logic [31:0]           prdata, q;
    logic [7:0]            cnt, c;
    logic [3:0]            src;
    int                    num_errors = 0;
    int                    n_compared = 0;
    int                    cyc = 0;
    int                    n;

    always #5 clk_i = ~clk_i;

    pth_timer dut_u (.clk_i(clk_i), .srst_i(srst_i), .apb_req_i(req), .apb_pready_o(pready),
        .apb_prdata_o(prdata), .apb_pslverr_o(perr), .ext_reset_src_i(src),
        .debug_freeze_i(freeze), .timer_count_o(cnt), .period_match_o(pmatch),
        .postscaled_pulse_o(pulse));
    pth_ers_model ers_u (.clk_i(clk_i), .src_o(src));

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors = num_errors + 1;
            close_out();
        end
    end

    task automatic close_out();
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic idle(input int k);
        repeat (k) @(posedge clk_i);
    endtask : idle

    // one idle cycle after each transfer keeps psel changes one per step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk_i);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t no pready", $time);
        end
        q = prdata;
        err = perr;
        req <= '0;
        @(posedge clk_i);
    endtask : apb

    task automatic setup(input logic [4:0] mode, input logic [1:0] sel, input logic [7:0] per,
                         input logic [4:0] post, input logic [31:0] ctrl);
        apb(1'b1, pth_pkg::OFS_TIMER_CONTROL, 32'h0);
        apb(1'b1, pth_pkg::OFS_HW_LIMIT_CTRL, 32'(mode));
        apb(1'b1, pth_pkg::OFS_EXT_RST_SEL, 32'(sel));
        apb(1'b1, pth_pkg::OFS_PERIOD_SETTING, 32'(per));
        apb(1'b1, pth_pkg::OFS_TIMER_CTRL_ONE, 32'(post));
        apb(1'b1, pth_pkg::OFS_TIMER_COUNT, 32'h0);
        apb(1'b1, pth_pkg::OFS_TIMER_CONTROL, ctrl);
    endtask : setup

    task automatic wait_pulse();
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pulse !== 1'b1 && n < 300);
    endtask : wait_pulse

    task automatic wait_cnt();
        c = cnt;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (cnt === c && n < 300);
    endtask : wait_cnt

    task automatic t_regs();
        apb(1'b0, pth_pkg::OFS_TIMER_COUNT, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, pth_pkg::OFS_PERIOD_SETTING, 32'h0);
        chk(q, 32'hff);
        apb(1'b1, pth_pkg::OFS_HW_LIMIT_CTRL, 32'h1f);
        apb(1'b0, pth_pkg::OFS_HW_LIMIT_CTRL, 32'h0);
        chk(q, 32'h1f);
        apb(1'b0, 8'h1c, 32'h0);
        chk(32'(err), 32'h1);
    endtask : t_regs

    // period 3, postscale ratio 2: a pulse every eight ticks
    task automatic t_free();
        setup(5'h00, 2'h0, 8'h03, 5'h01, 32'h1);
        wait_pulse();
        wait_pulse();
        chk(n, 32'h8);
        apb(1'b1, pth_pkg::OFS_TIMER_CONTROL, 32'h0);
        apb(1'b0, pth_pkg::OFS_TIMER_COUNT, 32'h0);
        c = q[7:0];
        idle(10);
        apb(1'b1, pth_pkg::OFS_TIMER_CONTROL, 32'h0);
        apb(1'b0, pth_pkg::OFS_TIMER_COUNT, 32'h0);
        chk(q, 32'(c));
    endtask : t_free

    // period written mid-run takes hold only after the next match
    task automatic t_buffer();
        setup(5'h00, 2'h0, 8'h03, 5'h00, 32'h1);
        wait_pulse();
        chk(pmatch, 32'h1);
        apb(1'b1, pth_pkg::OFS_PERIOD_SETTING, 32'h10);
        wait_pulse();
        chk(n, 32'h4);
        wait_pulse();
        chk(n, 32'h11);
        apb(1'b0, pth_pkg::OFS_PERIOD_SETTING, 32'h0);
        chk(q, 32'h10);
    endtask : t_buffer

    task automatic t_prescale();
        setup(5'h00, 2'h0, 8'hff, 5'h00, 32'h71);
        wait_cnt();
        wait_cnt();
        chk(n, 32'h80);
    endtask : t_prescale

    task automatic t_oneshot();
        setup(5'h08, 2'h0, 8'h04, 5'h00, 32'h1);
        wait_pulse();
        chk(n < 40, 32'h1);
        idle(3);
        apb(1'b0, pth_pkg::OFS_TIMER_CONTROL, 32'h0);
        chk(q[0], 32'h0);
        chk(cnt, 32'h0);
        apb(1'b1, pth_pkg::OFS_TIMER_CONTROL, 32'h1);
        wait_pulse();
        chk(n < 40, 32'h1);
    endtask : t_oneshot

    task automatic t_mono();
        setup(5'h11, 2'h1, 8'h04, 5'h00, 32'h1);
        idle(10);
        chk(cnt, 32'h0);
        ers_u.set_level(1, 1'b1);
        wait_pulse();
        chk(n < 40, 32'h1);
        idle(3);
        apb(1'b0, pth_pkg::OFS_TIMER_CONTROL, 32'h0);
        chk(q[0], 32'h1);
        chk(cnt, 32'h0);
        ers_u.set_level(1, 1'b0);
        ers_u.set_level(1, 1'b1);
        wait_pulse();
        chk(n < 40, 32'h1);
    endtask : t_mono

    task automatic t_gate();
        setup(5'h01, 2'h2, 8'hff, 5'h00, 32'h1);
        ers_u.set_level(2, 1'b1);
        idle(10);
        ers_u.set_level(2, 1'b0);
        idle(3);
        c = cnt;
        idle(10);
        chk(cnt, 32'(c));
        chk(c > 8'h05, 32'h1);
        ers_u.set_level(2, 1'b1);
        idle(3);
        chk(cnt > c, 32'h1);
    endtask : t_gate

    task automatic t_freeze();
        setup(5'h04, 2'h3, 8'hff, 5'h00, 32'h1);
        idle(40);
        freeze <= 1'b1;
        ers_u.set_level(3, 1'b1);
        idle(3);
        chk(cnt > 8'h28, 32'h1);
        ers_u.set_level(3, 1'b0);
        freeze <= 1'b0;
        ers_u.set_level(3, 1'b1);
        idle(2);
        chk(cnt < 8'h08, 32'h1);
    endtask : t_freeze

    // high-level reset holds zero; a stopped timer ignores the level
    task automatic t_level();
        setup(5'h07, 2'h0, 8'hff, 5'h00, 32'h1);
        ers_u.set_level(0, 1'b1);
        idle(3);
        chk(cnt, 32'h0);
        ers_u.set_level(0, 1'b0);
        idle(3);
        chk(cnt, 32'h2);
        apb(1'b1, pth_pkg::OFS_TIMER_CONTROL, 32'h0);
        ers_u.set_level(0, 1'b1);
        idle(3);
        chk(cnt, 32'h5);
    endtask : t_level

    initial begin
        idle(8);
        srst_i <= 1'b0;
        idle(1);
        t_regs();
        t_free();
        t_buffer();
        t_prescale();
        t_oneshot();
        t_mono();
        t_gate();
        t_freeze();
        t_level();
        close_out();
    end
endmodule : tb
